// >>> hdl/scan_dev.sv
// device end: tap controller, instruction, id, bypass and boundary registers
module scan_dev
  import scan_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  scan_if.dev LINK,
  input wire logic [scan_pkg::PIN_W-1:0] PINS_I,
  input wire logic [scan_pkg::PIN_W-1:0] CORE_PINS_I,
  input wire logic [scan_pkg::RDATA_W-1:0] CORE_RDATA_I,
  output logic [scan_pkg::PIN_W-1:0] PINS_O,
  output logic [scan_pkg::RDATA_W-1:0] RDATA_O,
  output logic RDATA_OE_O,
  output logic [3:0] TAP_STATE_O
);
  import scan_pkg::*;

  typedef struct packed {
    logic tck_m;
    logic [2:0] tck_sync;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    logic [PIN_W-1:0] pin_m;
    logic [PIN_W-1:0] pin_s;
    tap_state_e st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [ID_W-1:0] dr_sh;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] bsr_upd;
    logic byp;
    logic tdo;
    logic tdo_oe;
    logic [PIN_W-1:0] pins;
    logic [RDATA_W-1:0] rdata;
    logic rdata_oe;
  } dev_s;

  dev_s cur_ff;
  dev_s nxt_ff;
  logic rise;
  logic fall;

  // edge finding on the synchronised test clock
  assign rise = cur_ff.tck_sync[1] & ~cur_ff.tck_sync[2];
  assign fall = ~cur_ff.tck_sync[1] & cur_ff.tck_sync[2];

  always_comb begin
    nxt_ff = cur_ff;
    // test clock passes three flops and pins two; a pin moving at capture may land either way
    nxt_ff.tck_m = LINK.tck;
    nxt_ff.tck_sync = {cur_ff.tck_sync[1], cur_ff.tck_sync[0], cur_ff.tck_m};
    nxt_ff.pin_m = PINS_I;
    nxt_ff.pin_s = cur_ff.pin_m;
    nxt_ff.tms_m = LINK.tms;
    nxt_ff.tms_s = cur_ff.tms_m;
    nxt_ff.tdi_m = LINK.tdi;
    nxt_ff.tdi_s = cur_ff.tdi_m;
    if (rise) begin
      // register actions for the state being left
      case (cur_ff.st)
        ST_RESET: begin
          nxt_ff.ir = OP_IDCODE;
          nxt_ff.bsr_upd[OE_CELL] = 1'b0;
        end
        ST_CAP_IR: nxt_ff.ir_sh = {1'b0, IR_CAPTURE_PAT};
        ST_SH_IR: nxt_ff.ir_sh = {cur_ff.tdi_s, cur_ff.ir_sh[IR_W-1:1]};
        ST_UPD_IR: nxt_ff.ir = cur_ff.ir_sh;
        ST_CAP_DR: begin
          case (cur_ff.ir)
            OP_IDCODE: nxt_ff.dr_sh = ID_VALUE;
            OP_BYPASS: nxt_ff.byp = 1'b0;
            OP_EXTEST, OP_SAMPLE, OP_HIZ_SAMPLE:
              nxt_ff.bsr = {cur_ff.bsr_upd[OE_CELL], cur_ff.pin_s};
            default: nxt_ff.byp = 1'b0;
          endcase
        end
        ST_SH_DR: begin
          case (cur_ff.ir)
            OP_IDCODE: nxt_ff.dr_sh = {cur_ff.tdi_s, cur_ff.dr_sh[ID_W-1:1]};
            OP_EXTEST, OP_SAMPLE, OP_HIZ_SAMPLE:
              nxt_ff.bsr = {cur_ff.tdi_s, cur_ff.bsr[BSR_W-1:1]};
            default: nxt_ff.byp = cur_ff.tdi_s;
          endcase
        end
        ST_UPD_DR: begin
          if (cur_ff.ir == OP_SAMPLE || cur_ff.ir == OP_EXTEST) begin
            nxt_ff.bsr_upd = cur_ff.bsr;
          end
        end
        default: ;
      endcase
      // standard sixteen-state walk
      case (cur_ff.st)
        ST_RESET: nxt_ff.st = cur_ff.tms_s ? ST_RESET : ST_IDLE;
        ST_IDLE: nxt_ff.st = cur_ff.tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: nxt_ff.st = cur_ff.tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: nxt_ff.st = cur_ff.tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: nxt_ff.st = cur_ff.tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: nxt_ff.st = cur_ff.tms_s ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: nxt_ff.st = cur_ff.tms_s ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: nxt_ff.st = cur_ff.tms_s ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: nxt_ff.st = cur_ff.tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: nxt_ff.st = cur_ff.tms_s ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: nxt_ff.st = cur_ff.tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: nxt_ff.st = cur_ff.tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: nxt_ff.st = cur_ff.tms_s ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: nxt_ff.st = cur_ff.tms_s ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: nxt_ff.st = cur_ff.tms_s ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: nxt_ff.st = cur_ff.tms_s ? ST_SEL_DR : ST_IDLE;
        default: nxt_ff.st = ST_RESET;
      endcase
    end
    // serial output changes only on the falling test clock edge
    if (fall) begin
      nxt_ff.tdo_oe = (cur_ff.st == ST_SH_DR) || (cur_ff.st == ST_SH_IR);
      if (cur_ff.st == ST_SH_IR) begin
        nxt_ff.tdo = cur_ff.ir_sh[0];
      end else begin
        case (cur_ff.ir)
          OP_IDCODE: nxt_ff.tdo = cur_ff.dr_sh[0];
          OP_EXTEST, OP_SAMPLE, OP_HIZ_SAMPLE: nxt_ff.tdo = cur_ff.bsr[0];
          default: nxt_ff.tdo = cur_ff.byp;
        endcase
      end
    end
    // pin and read-data drivers follow the current instruction
    if (cur_ff.ir == OP_EXTEST) begin
      nxt_ff.pins = cur_ff.bsr_upd[PIN_W-1:0];
      nxt_ff.rdata = cur_ff.bsr_upd[RDATA_W-1:0];
      nxt_ff.rdata_oe = cur_ff.bsr_upd[OE_CELL];
    end else begin
      nxt_ff.pins = CORE_PINS_I;
      nxt_ff.rdata = CORE_RDATA_I;
      nxt_ff.rdata_oe = (cur_ff.ir != OP_HIZ_SAMPLE);
    end
  end

  // single state register; reset lands in the reset state with id current
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cur_ff <= '0;
      cur_ff.st <= ST_RESET;
      cur_ff.ir <= OP_IDCODE;
      cur_ff.rdata_oe <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign LINK.tdo = cur_ff.tdo;
  assign LINK.tdo_oe = cur_ff.tdo_oe;
  assign PINS_O = cur_ff.pins;
  assign RDATA_O = cur_ff.rdata;
  assign RDATA_OE_O = cur_ff.rdata_oe;
  assign TAP_STATE_O = cur_ff.st;
endmodule // scan_dev

// >>> shared/scan_pkg.sv
// shared constants for the boundary-scan instruction layer
package scan_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 109;
  localparam int OE_CELL = 108;
  localparam int PIN_W = 108;
  localparam int RDATA_W = 36;
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE = 3'h1;
  localparam logic [2:0] OP_HIZ_SAMPLE = 3'h2;
  localparam logic [2:0] OP_SAMPLE = 3'h4;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam logic [ID_W-1:0] ID_VALUE = 32'h00ABC0DF; // arbitrary identity value
  localparam int RESET_TMS_EDGES = 5;
  localparam int HALF_DIV = 8; // host link clock half period in core clocks
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_e;
endpackage

// >>> shared/scan_if.sv
// link wires between scan controller and device port
interface scan_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// >>> hdl/scan_host.sv
// host end: makes test clock, shifts one tms/tdi bit per test clock cycle
module scan_host
  import scan_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  scan_if.host LINK,
  input wire logic STEP_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic READY_O,
  output logic TDO_VALID_O,
  output logic TDO_O
);
  import scan_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic busy;
    logic rdy;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_m;
    logic tdo_s;
    logic vld;
    logic tdo_bit;
  } host_s;

  host_s cur_ff;
  host_s nxt_ff;

  // one step: tck low half, rising edge, high half, falling edge
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.tdo_m = LINK.tdo;
    nxt_ff.tdo_s = cur_ff.tdo_m;
    nxt_ff.vld = 1'b0;
    if (!cur_ff.busy) begin
      if (STEP_I) begin
        nxt_ff.busy = 1'b1;
        nxt_ff.tms = TMS_I;
        nxt_ff.tdi = TDI_I;
        nxt_ff.div = 8'h00;
      end
    end else if (cur_ff.div == 8'(2 * HALF_DIV - 1)) begin
      nxt_ff.tck = 1'b0;
      nxt_ff.busy = 1'b0;
    end else begin
      nxt_ff.div = cur_ff.div + 8'h01;
      // rise after a low half keeps tms/tdi stable across the edge
      if (cur_ff.div == 8'(HALF_DIV - 1)) begin
        nxt_ff.tck = 1'b1;
        nxt_ff.vld = 1'b1;
        nxt_ff.tdo_bit = cur_ff.tdo_s;
      end
    end
    // ready kept as its own flop so the output needs no gate
    nxt_ff.rdy = ~nxt_ff.busy;
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cur_ff <= '0;
      cur_ff.tms <= 1'b1;
      cur_ff.rdy <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign LINK.tck = cur_ff.tck;
  assign LINK.tms = cur_ff.tms;
  assign LINK.tdi = cur_ff.tdi;
  assign READY_O = cur_ff.rdy;
  assign TDO_VALID_O = cur_ff.vld;
  assign TDO_O = cur_ff.tdo_bit;
endmodule // scan_host

// >>> verif/scan_link_chk.sv
// wire-level checks on the scan link between host and device
module scan_link_chk (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [2:0] hi_ff;
  logic [2:0] rises_ff;
  logic tck_d_ff;
  // tck rises since the last five-high run; shifting cannot start before four
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_ff <= 3'h0;
      rises_ff <= 3'h0;
      tck_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= tck_i;
      if (tck_i && !tck_d_ff) begin
        hi_ff <= tms_i ? hi_ff + {2'h0, hi_ff != 3'h5} : 3'h0;
        rises_ff <= (tms_i && hi_ff >= 3'h4) ? 3'h0 : rises_ff + {2'h0, rises_ff != 3'h7};
      end
    end
  end
  tck_high_len_a: assert property ($rose(tck_i) |-> tck_i [*8] ##1 !tck_i)
    else $error("tck high time wrong");
  tck_low_len_a: assert property ($fell(tck_i) |-> !tck_i [*8])
    else $error("tck low time too short");
  tms_hold_a: assert property ($rose(tck_i) |-> $stable(tms_i) [*8])
    else $error("tms moved while tck high");
  tdi_hold_a: assert property ($rose(tck_i) |-> $stable(tdi_i) [*8])
    else $error("tdi moved while tck high");
  tdo_hold_a: assert property ($rose(tck_i) |-> $stable(tdo_i) [*8])
    else $error("tdo moved while tck high");
  tdo_low_edge_a: assert property ($changed(tdo_i) |-> !tck_i)
    else $error("tdo changed with tck high");
  oe_after_reset_a: assert property (tdo_oe_i |-> rises_ff >= 3'h4)
    else $error("tdo driven too soon after tap reset");
  // drop waits for the next falling edge: eight high cycles plus the device edge finder
  oe_exit_a: assert property ($rose(tck_i) && tdo_oe_i && tms_i |-> ##[9:14] !tdo_oe_i)
    else $error("tdo still driven after shift exit");
endmodule // scan_link_chk

// >>> verif/boundary_scan_tap_instructions_test.sv
// end-to-end bench: host and device joined by the scan link
module boundary_scan_tap_instructions_test;
  timeunit 1ns;
  timeprecision 100ps;
  import scan_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic step = 1'b0;
  logic tms_in = 1'b1;
  logic tdi_in = 1'b0;
  logic ready, tvalid, tdo_seen, rd_oe;
  // pins move only between scans, so no captured bit is discarded
  logic [PIN_W-1:0] pins = {4{27'h5A3C96F}};
  logic [PIN_W-1:0] core_pins = {4{27'h0F0F0F0}};
  logic [PIN_W-1:0] pins_o;
  logic [RDATA_W-1:0] core_rd = 36'hC3C3C3C3C;
  logic [RDATA_W-1:0] rd;
  logic [3:0] st;
  logic [127:0] q;
  logic [127:0] p = {20'h1, {4{27'h12345AB}}};
  logic [7:0] byp_pats [4] = '{8'hA5, 8'h3C, 8'h81, 8'hFF};
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  scan_if link();
  always #2.5 clk = ~clk;
  scan_dev i_scan_dev (.CLK_I(clk), .NRST_I(nrst), .LINK(link), .PINS_I(pins), .CORE_PINS_I(core_pins),
    .CORE_RDATA_I(core_rd), .PINS_O(pins_o), .RDATA_O(rd), .RDATA_OE_O(rd_oe), .TAP_STATE_O(st));
  scan_host i_scan_host (.CLK_I(clk), .NRST_I(nrst), .LINK(link), .STEP_I(step), .TMS_I(tms_in),
    .TDI_I(tdi_in), .READY_O(ready), .TDO_VALID_O(tvalid), .TDO_O(tdo_seen));
  scan_link_chk i_scan_link_chk (.CLK_I(clk), .NRST_I(nrst), .tck_i(link.tck), .tms_i(link.tms),
    .tdi_i(link.tdi), .tdo_i(link.tdo), .tdo_oe_i(link.tdo_oe));
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one test clock cycle; the waits are bounded so a dead host returns the stale tdo bit instead of hanging
  task automatic step1(input logic m, input logic d, output logic o);
    int n;
    @(posedge clk) #1;
    step = 1'b1;
    tms_in = m;
    tdi_in = d;
    @(posedge clk) #1;
    step = 1'b0;
    for (n = 0; n < 40 && tvalid !== 1'b1; n++) @(posedge clk) #1;
    o = tdo_seen;
    for (n = 0; n < 40 && ready !== 1'b1; n++) @(posedge clk) #1;
  endtask
  // idle to idle through one ir or dr scan of n bits, lsb first
  task automatic scan(input bit ir, input logic [127:0] din, input int n, output logic [127:0] dout);
    logic o;
    dout = '0;
    step1(1'b1, 1'b0, o);
    if (ir) step1(1'b1, 1'b0, o);
    step1(1'b0, 1'b0, o);
    step1(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step1(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step1(1'b1, 1'b0, o);
    step1(1'b0, 1'b0, o);
  endtask
  task automatic tap_reset;
    logic o;
    repeat (5) step1(1'b1, 1'b0, o);
    chk("tap state", st, ST_RESET);
    step1(1'b0, 1'b0, o);
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    chk("state after power-up", st, ST_RESET);
    tap_reset;
    scan(0, '0, ID_W, q);
    chk("id code", q[31:0], ID_VALUE);
    foreach (byp_pats[k]) begin
      scan(1, OP_BYPASS, IR_W, q);
      chk("ir capture", q[2:0], 3'h1);
      scan(0, byp_pats[k], 8, q);
      chk("bypass path", q[7:0], {byp_pats[k][6:0], 1'b0});
    end
    scan(1, OP_SAMPLE, IR_W, q);
    scan(0, p, BSR_W, q);
    chk("sampled pins", q[107:0], pins);
    chk("enable cell reset", q[OE_CELL], 1'b0);
    scan(0, p, BSR_W, q);
    chk("enable cell latched", q[OE_CELL], 1'b1);
    chk("pins untouched", pins_o, core_pins);
    chk("read enable", rd_oe, 1'b1);
    scan(1, OP_HIZ_SAMPLE, IR_W, q);
    chk("hiz floats", rd_oe, 1'b0);
    scan(0, '0, BSR_W, q);
    chk("hiz chain", q[107:0], pins);
    scan(1, OP_EXTEST, IR_W, q);
    chk("preload on pins", pins_o, p[107:0]);
    chk("preload read data", rd, p[35:0]);
    chk("read drives", rd_oe, 1'b1);
    pins = ~pins;
    scan(0, p ^ (128'h1 << OE_CELL), BSR_W, q);
    chk("read floats", rd_oe, 1'b0);
    chk("extest capture", q[107:0], pins);
    scan(0, p, BSR_W, q);
    chk("read drives again", rd_oe, 1'b1);
    tap_reset;
    scan(0, '0, ID_W, q);
    chk("id after reset", q[31:0], ID_VALUE);
    scan(1, OP_EXTEST, IR_W, q);
    chk("cell low after reset", rd_oe, 1'b0);
    complete_run;
  end
endmodule // boundary_scan_tap_instructions_test
